// ### rtl/grpc_pkg.sv
package grpc_pkg;
    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_COMPARE = 8'h04;
    localparam logic [7:0] OFS_PROTECT = 8'h08;
    localparam logic [7:0] OFS_POINTER = 8'h0c;
    localparam logic [7:0] OFS_DATA = 8'h10;
    localparam logic [7:0] OFS_RED_PAL = 8'h14;
    localparam logic [7:0] OFS_GREEN_PAL = 8'h18;
    localparam logic [7:0] OFS_BLUE_PAL = 8'h1c;
    localparam logic [7:0] OFS_CUR_H = 8'h20;
    localparam logic [7:0] OFS_CUR_V = 8'h24;
    localparam logic [7:0] OFS_STATUS = 8'h28;
    // ------------------------------------------------------------
    // control register fields
    // ------------------------------------------------------------
    localparam int CTL_VSTEP = 0;
    localparam int CTL_INC = 1;
    localparam int CTL_OP = 2;
    localparam int CTL_SWAP = 5;
    localparam int CTL_FOUR = 6;
    localparam int CTL_CUR_EN = 7;
    localparam int CTL_STYLE = 8;
    localparam int CTL_CCOL = 10;
    localparam logic [12:0] CTRL_RESET = 13'h0002;
    // ------------------------------------------------------------
    // logic operation codes
    // ------------------------------------------------------------
    localparam logic [2:0] OP_REPLACE = 3'h0;
    localparam logic [2:0] OP_OR = 3'h1;
    localparam logic [2:0] OP_AND = 3'h2;
    localparam logic [2:0] OP_XOR = 3'h3;
    localparam logic [2:0] OP_RD_EQ = 3'h4;
    localparam logic [2:0] OP_RD_NE = 3'h5;
    localparam logic [2:0] OP_WR_EQ = 3'h6;
    localparam logic [2:0] OP_WR_NE = 3'h7;
    // ------------------------------------------------------------
    // memory geometry and scan
    // ------------------------------------------------------------
    localparam logic [7:0] COL_LAST = 8'h3f;
    localparam logic [7:0] ROW_LAST = 8'h4f;
    localparam int MEM_WORDS = 5120;
    localparam logic [6:0] PIX_LAST = 7'h7f;
    localparam logic [6:0] LINE_LAST = 7'h4f;
    localparam int BLINK_BIT = 5;
endpackage : grpc_pkg

// ### rtl/grpc_merge_if.sv
interface grpc_merge_if;
    logic [15:0] host_word; // raw host write data
    logic [15:0] latch_word; // fetched original word
    logic [2:0] op_code; // logic / compare selection
    logic [7:0] compare; // byte compare value
    logic [15:0] protect; // per-bit write protect
    logic swap; // exchange bytes first
    logic [15:0] result; // word to store
    modport calc (input host_word, latch_word, op_code, compare, protect, swap, output result);
    modport user (output host_word, latch_word, op_code, compare, protect, swap, input result);
endinterface : grpc_merge_if

// ### rtl/grpc_merge.sv
module grpc_merge
    import grpc_pkg::*;
(
    // operands and result
    grpc_merge_if.calc m
);
    // ------------------------------------------------------------
    // swap stage
    // ------------------------------------------------------------
    wire [15:0] swapped = m.swap ? {m.host_word[7:0], m.host_word[15:8]} : m.host_word;
    // logical result before masking
    wire [15:0] logic_word = (m.op_code == OP_OR) ? (m.latch_word | swapped) :
        (m.op_code == OP_AND) ? (m.latch_word & swapped) :
        (m.op_code == OP_XOR) ? (m.latch_word ^ swapped) : swapped;
    wire [15:0] cand;
    // ------------------------------------------------------------
    // per-byte conditional write
    // ------------------------------------------------------------
    genvar b;
    generate
        for (b = 0; b < 2; b++) begin : g_byte
            wire [7:0] old_b = m.latch_word[8*b +: 8];
            wire [7:0] new_b = swapped[8*b +: 8];
            // read compare uses stored byte, write compare the host byte
            wire [7:0] probe = m.op_code[1] ? new_b : old_b;
            wire hit = (probe == m.compare) ^ m.op_code[0];
            assign cand[8*b +: 8] = !m.op_code[2] ? logic_word[8*b +: 8] : (hit ? new_b : old_b);
        end
    endgenerate
    // protected bits keep the stored value
    assign m.result = (m.latch_word & m.protect) | (cand & ~m.protect);
endmodule : grpc_merge

// ### rtl/grpc_top.sv
// The APB interface to the registers and the address map were chosen for this implementation.
module grpc_top
    import grpc_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // dot stream
    output logic [6:0] dot_col,
    output logic [6:0] dot_row,
    output logic dot_red_on,
    output logic dot_green_on,
    output logic dot_blue_on,
    output logic frame_start
);
    // ------------------------------------------------------------
    // storage
    // ------------------------------------------------------------
    logic [15:0] pixel_memory [0:MEM_WORDS-1]; // display words
    logic [12:0] ctrl; // mode and cursor controls
    logic [7:0] compare_value; // conditional write reference
    logic [15:0] write_protect_bits; // per-bit protect
    logic [15:0] ram_pointer; // row in high byte, column low
    logic [15:0] read_latch; // original word for merge
    logic [31:0] red_palette_entry; // eight nibbles
    logic [31:0] green_palette_entry; // eight nibbles
    logic [15:0] blue_palette_entry; // four nibbles
    logic [6:0] cursor_left; // window left pixel
    logic [6:0] cursor_right; // window right pixel
    logic [6:0] cursor_top; // window top line
    logic [6:0] cursor_bottom; // window bottom line
    logic [6:0] scan_x; // current pixel
    logic [6:0] scan_y; // current line
    logic [5:0] frame_count; // frame counter, blink phase

    // ------------------------------------------------------------
    // control fields
    // ------------------------------------------------------------
    wire vertical_step_select = ctrl[CTL_VSTEP];
    wire step_increment = ctrl[CTL_INC];
    wire [2:0] logic_op_code = ctrl[CTL_OP +: 3];
    wire byte_exchange_enable = ctrl[CTL_SWAP];
    wire four_color_mode = ctrl[CTL_FOUR];
    wire cursor_enable = ctrl[CTL_CUR_EN];
    wire [1:0] cursor_style = ctrl[CTL_STYLE +: 2];
    wire cursor_red_on = ctrl[CTL_CCOL];
    wire cursor_green_on = ctrl[CTL_CCOL + 1];
    wire cursor_blue_on = ctrl[CTL_CCOL + 2];

    // ------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------
    wire access = psel & penable; // access phase
    wire first_cycle = access & ~pready; // decide answer here
    wire done = access & pready; // transfer completes
    wire wr_done = done & pwrite; // write takes effect
    wire hit_ctrl = paddr == OFS_CTRL;
    wire hit_cmp = paddr == OFS_COMPARE;
    wire hit_prot = paddr == OFS_PROTECT;
    wire hit_ptr = paddr == OFS_POINTER;
    wire hit_data = paddr == OFS_DATA;
    wire hit_red = paddr == OFS_RED_PAL;
    wire hit_green = paddr == OFS_GREEN_PAL;
    wire hit_blue = paddr == OFS_BLUE_PAL;
    wire hit_ch = paddr == OFS_CUR_H;
    wire hit_cv = paddr == OFS_CUR_V;
    wire hit_stat = paddr == OFS_STATUS;
    wire mapped = hit_ctrl | hit_cmp | hit_prot | hit_ptr | hit_data | hit_red |
        hit_green | hit_blue | hit_ch | hit_cv | hit_stat;

    // ------------------------------------------------------------
    // pointer to memory index
    // ------------------------------------------------------------
    wire [7:0] ptr_row = ram_pointer[15:8];
    wire [7:0] ptr_col = ram_pointer[7:0];
    wire ptr_ok = (ptr_row <= ROW_LAST) && (ptr_col <= COL_LAST);
    wire [12:0] ptr_index = {ptr_row[6:0], ptr_col[5:0]};
    wire [15:0] ptr_word = ptr_ok ? pixel_memory[ptr_index] : 16'h0000;

    // ------------------------------------------------------------
    // read multiplexer
    // ------------------------------------------------------------
    wire [31:0] read_mux = hit_ctrl ? {19'h00000, ctrl} :
        hit_cmp ? {24'h000000, compare_value} :
        hit_prot ? {16'h0000, write_protect_bits} :
        hit_ptr ? {16'h0000, ram_pointer} :
        hit_data ? {16'h0000, ptr_word} :
        hit_red ? red_palette_entry :
        hit_green ? green_palette_entry :
        hit_blue ? {16'h0000, blue_palette_entry} :
        hit_ch ? {17'h00000, cursor_right, 1'b0, cursor_left} :
        hit_cv ? {17'h00000, cursor_bottom, 1'b0, cursor_top} :
        hit_stat ? {18'h00000, frame_count, 1'b0, scan_y} : 32'h0000_0000;

    // ------------------------------------------------------------
    // merge unit
    // ------------------------------------------------------------
    grpc_merge_if mrg ();
    assign mrg.host_word = pwdata[15:0];
    assign mrg.latch_word = read_latch;
    assign mrg.op_code = logic_op_code;
    assign mrg.compare = compare_value;
    assign mrg.protect = write_protect_bits;
    assign mrg.swap = byte_exchange_enable;
    grpc_merge u_merge (
        .m(mrg.calc)
    );

    // ------------------------------------------------------------
    // pointer stepping
    // ------------------------------------------------------------
    wire [7:0] col_up = (ptr_col >= COL_LAST) ? 8'h00 : ptr_col + 8'h01;
    wire [7:0] col_down = (ptr_col == 8'h00) ? COL_LAST : ptr_col - 8'h01;
    wire [7:0] row_down = (ptr_row >= ROW_LAST) ? 8'h00 : ptr_row + 8'h01;
    wire col_edge = step_increment ? (ptr_col >= COL_LAST) : (ptr_col == 8'h00);
    // horizontal: step column, drop one row at the edge
    wire [15:0] next_h_ptr = {col_edge ? row_down : ptr_row,
        step_increment ? col_up : col_down};
    // vertical: next row, at the bottom back to top of next column
    wire [15:0] next_v_ptr = (ptr_row >= ROW_LAST) ?
        {8'h00, step_increment ? col_up : col_down} :
        {row_down, ptr_col};
    wire [15:0] next_ptr = vertical_step_select ? next_v_ptr : next_h_ptr;

    // ------------------------------------------------------------
    // apb answer: one wait state on every access
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready <= first_cycle;
            if (first_cycle) begin
                // read data and error stand while pready is high
                prdata <= pwrite ? 32'h0000_0000 : read_mux;
                pslverr <= ~mapped;
            end else begin
                // back to zero as soon as the answer cycle is over
                prdata <= 32'h0000_0000;
                pslverr <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // read latch: original word fetched inside the strobe
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            read_latch <= 16'h0000;
        end else if (first_cycle & pwrite & hit_data) begin
            // the wait state makes the bus cycle as long as a read
            read_latch <= ptr_word;
        end
    end

    // ------------------------------------------------------------
    // memory write of merged word
    // ------------------------------------------------------------
    always_ff @(posedge pclk) begin
        if (wr_done & hit_data & ptr_ok) begin
            pixel_memory[ptr_index] <= mrg.result;
        end
    end

    // ------------------------------------------------------------
    // pointer register
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ram_pointer <= 16'h0000;
        end else if (wr_done & hit_ptr) begin
            ram_pointer <= pwdata[15:0];
        end else if (wr_done & hit_data) begin
            // steps even when compare blocked every byte
            ram_pointer <= next_ptr;
        end
    end

    // ------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= CTRL_RESET;
            compare_value <= 8'h00;
            write_protect_bits <= 16'h0000;
        end else begin
            if (wr_done & hit_ctrl) ctrl <= pwdata[12:0];
            if (wr_done & hit_cmp) compare_value <= pwdata[7:0];
            if (wr_done & hit_prot) write_protect_bits <= pwdata[15:0];
        end
    end

    // ------------------------------------------------------------
    // palettes and cursor window
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            red_palette_entry <= 32'h0000_0000;
            green_palette_entry <= 32'h0000_0000;
            blue_palette_entry <= 16'h0000;
            cursor_left <= 7'h00;
            cursor_right <= 7'h00;
            cursor_top <= 7'h00;
            cursor_bottom <= 7'h00;
        end else begin
            if (wr_done & hit_red) red_palette_entry <= pwdata;
            if (wr_done & hit_green) green_palette_entry <= pwdata;
            if (wr_done & hit_blue) blue_palette_entry <= pwdata[15:0];
            if (wr_done & hit_ch) begin
                cursor_left <= pwdata[6:0];
                cursor_right <= pwdata[14:8];
            end
            if (wr_done & hit_cv) begin
                cursor_top <= pwdata[6:0];
                cursor_bottom <= pwdata[14:8];
            end
        end
    end

    // ------------------------------------------------------------
    // scan counters
    // ------------------------------------------------------------
    wire line_end = scan_x == PIX_LAST;
    wire frame_end = line_end && (scan_y == LINE_LAST);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            scan_x <= 7'h00;
            scan_y <= 7'h00;
            frame_count <= 6'h00;
        end else begin
            scan_x <= line_end ? 7'h00 : scan_x + 7'h01;
            if (frame_end) begin
                scan_y <= 7'h00;
                frame_count <= frame_count + 6'h01;
            end else if (line_end) begin
                scan_y <= scan_y + 7'h01;
            end
        end
    end

    // ------------------------------------------------------------
    // pixel fetch
    // ------------------------------------------------------------
    // full colour: two pixels a word; four colour: eight a word
    wire [5:0] scan_col = four_color_mode ? {2'b00, scan_x[6:3]} : scan_x[6:1];
    wire [15:0] scan_word = pixel_memory[{scan_y, scan_col}];
    wire [7:0] scan_byte = scan_x[0] ? scan_word[7:0] : scan_word[15:8];
    wire [15:0] scan_shift = scan_word >> {~scan_x[2:0], 1'b0};
    wire [1:0] pair = scan_shift[1:0];
    // palette indices
    wire [2:0] red_idx = four_color_mode ? {1'b0, pair} : scan_byte[7:5];
    wire [2:0] green_idx = four_color_mode ? {1'b0, pair} : scan_byte[4:2];
    wire [1:0] blue_idx = four_color_mode ? pair : scan_byte[1:0];
    wire [3:0] pal_val [3];
    assign pal_val[0] = red_palette_entry[{red_idx, 2'b00} +: 4];
    assign pal_val[1] = green_palette_entry[{green_idx, 2'b00} +: 4];
    assign pal_val[2] = blue_palette_entry[{blue_idx, 2'b00} +: 4];

    // ------------------------------------------------------------
    // cursor decision
    // ------------------------------------------------------------
    wire in_window = (scan_x >= cursor_left) && (scan_x <= cursor_right) &&
        (scan_y >= cursor_top) && (scan_y <= cursor_bottom);
    wire blink_shown = ~cursor_style[1] | frame_count[BLINK_BIT];
    wire cursor_here = cursor_enable & in_window & blink_shown;
    wire cursor_fixed = cursor_here & ~cursor_style[0];
    wire cursor_invert = cursor_here & cursor_style[0];
    wire [2:0] cursor_colour = {cursor_blue_on, cursor_green_on, cursor_red_on};
    // dot-dependent offset spreads the skipped frames
    wire [3:0] phase = frame_count[3:0] + {scan_x[0], scan_y[0], scan_x[1], scan_y[1]};
    wire [2:0] lit;

    // ------------------------------------------------------------
    // per-channel grayscale
    // ------------------------------------------------------------
    genvar c;
    generate
        for (c = 0; c < 3; c++) begin : g_chan
            wire [3:0] val = cursor_invert ? ~pal_val[c] : pal_val[c];
            // lit frames out of sixteen: 0, else value plus one
            wire [4:0] level = (val == 4'h0) ? 5'h00 : {1'b0, val} + 5'h01;
            wire gray_on = {1'b0, phase} < level;
            assign lit[c] = cursor_fixed ? cursor_colour[c] : gray_on;
        end
    endgenerate

    // ------------------------------------------------------------
    // registered dot outputs
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dot_col <= 7'h00;
            dot_row <= 7'h00;
            dot_red_on <= 1'b0;
            dot_green_on <= 1'b0;
            dot_blue_on <= 1'b0;
            frame_start <= 1'b0;
        end else begin
            dot_col <= scan_x;
            dot_row <= scan_y;
            dot_red_on <= lit[0];
            dot_green_on <= lit[1];
            dot_blue_on <= lit[2];
            frame_start <= (scan_x == 7'h00) && (scan_y == 7'h00);
        end
    end
endmodule : grpc_top

// ### testbench/grpc_host_model.sv
module grpc_host_model (
    // clock and answer
    input wire logic pclk,
    input wire logic pready,
    input wire logic [31:0] prdata,
    input wire logic pslverr,
    // request
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata
);
    timeunit 1ns;
    timeprecision 1ns;
    // idle bus from time zero
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
    end
    // one transfer; writes last exactly as long as reads
    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q, output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        pwdata <= ~d; // stale data not left on the bus
    endtask : xfer
endmodule : grpc_host_model

// ### testbench/grpc_top_assertions.sv
module grpc_top_assertions
    import grpc_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // dot stream
    input wire logic [6:0] dot_col,
    input wire logic [6:0] dot_row,
    input wire logic dot_red_on,
    input wire logic dot_green_on,
    input wire logic dot_blue_on,
    input wire logic frame_start
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ----
    // bus answers
    // ----
    a_wait_state: assert property (psel && penable && !pready |=> pready)
        else $error("answer missing after one wait state");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("ready held too long");
    a_read_idle: assert property (!pready |-> prdata == 32'h0)
        else $error("read data outside answer");
    a_write_quiet: assert property (pready && pwrite |-> prdata == 32'h0)
        else $error("fetched word returned on write");
    // ----
    // dot scan
    // ----
    a_frame_origin: assert property (frame_start |-> dot_col == 7'h00 && dot_row == 7'h00)
        else $error("frame pulse off origin");
    a_scan_first: assert property (frame_start |=> dot_col == 7'h01 && dot_row == 7'h00)
        else $error("scan did not leave origin");
    a_col_step: assert property (dot_col != 7'h00 && dot_col != 7'h7f |=> dot_col == $past(dot_col) + 7'h01)
        else $error("column did not step");
    a_line_wrap: assert property (dot_col == 7'h7f && dot_row != 7'h4f
        |=> dot_col == 7'h00 && dot_row == $past(dot_row) + 7'h01)
        else $error("line wrap wrong");
    a_frame_wrap: assert property (dot_col == 7'h7f && dot_row == 7'h4f |=> frame_start)
        else $error("frame did not restart");
    a_frame_gap: assert property (frame_start |=> !frame_start [*8])
        else $error("frame pulse repeated");
endmodule : grpc_top_assertions
bind grpc_top grpc_top_assertions grpc_top_assertions_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .dot_col(dot_col), .dot_row(dot_row), .dot_red_on(dot_red_on),
    .dot_green_on(dot_green_on), .dot_blue_on(dot_blue_on), .frame_start(frame_start));

// ### testbench/grpc_top_tb.sv
module grpc_top_tb
    import grpc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic pclk, presetn, rv_err;
    logic [31:0] rv; // last read data
    wire psel, penable, pwrite, pready, pslverr, dot_red_on, dot_green_on, dot_blue_on, frame_start;
    wire [7:0] paddr;
    wire [31:0] pwdata, prdata;
    wire [6:0] dot_col, dot_row;
    int n_errors, cmp_count;
    grpc_top grpc_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .dot_col(dot_col), .dot_row(dot_row), .dot_red_on(dot_red_on), .dot_green_on(dot_green_on),
        .dot_blue_on(dot_blue_on), .frame_start(frame_start));
    grpc_host_model grpc_host_model_inst (.pclk(pclk), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
    // 20 mhz clock
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end
    // compare one result
    task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task wr(input logic [7:0] a, input logic [31:0] d);
        grpc_host_model_inst.xfer(1'b1, a, d, rv, rv_err);
    endtask : wr
    task rd(input logic [7:0] a);
        grpc_host_model_inst.xfer(1'b0, a, 32'h0, rv, rv_err);
    endtask : rd
    // control, pointer, then one data word
    task put(input logic [15:0] p, input logic [12:0] c, input logic [15:0] d);
        wr(OFS_CTRL, {19'h0, c});
        wr(OFS_POINTER, {16'h0, p});
        wr(OFS_DATA, {16'h0, d});
    endtask : put
    task get(input logic [15:0] p, input logic [15:0] e);
        wr(OFS_POINTER, {16'h0, p});
        rd(OFS_DATA);
        chk("data word", {16'h0, e}, rv);
    endtask : get
    // wait for a pixel, then check its three dots
    task dot(input logic [6:0] x, input logic [6:0] y, input logic [2:0] e);
        int n;
        n = 0;
        // one edge for a new control word to reach the dots
        @(posedge pclk);
        do begin
            @(negedge pclk);
            n++;
        end while (!(dot_col === x && dot_row === y) && n < 20000);
        chk("dot found", 32'h1, {31'h0, n < 20000});
        chk("dot colour", {29'h0, e}, {29'h0, dot_red_on, dot_green_on, dot_blue_on});
    endtask : dot
    // reference merge with swap on: swap, operation, mask
    function automatic logic [15:0] merge(input logic [2:0] op, input logic [15:0] b, input logic [15:0] h,
        input logic [7:0] c, input logic [15:0] p);
        logic [15:0] s;
        logic [15:0] r;
        logic [7:0] f;
        s = {h[7:0], h[15:8]};
        case (op)
            3'h1: r = b | s;
            3'h2: r = b & s;
            3'h3: r = b ^ s;
            default: r = s;
        endcase
        if (op[2]) for (int i = 0; i < 2; i++) begin
            f = op[1] ? s[i*8+:8] : b[i*8+:8];
            r[i*8+:8] = ((f == c) ^ op[0]) ? s[i*8+:8] : b[i*8+:8];
        end
        return (r & ~p) | (b & p);
    endfunction : merge
    task conclude;
        $display("compares %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : conclude
    // step cases: start, control, expected next pointer
    logic [15:0] sp[5] = '{16'h053f, 16'h0500, 16'h4f10, 16'h4f10, 16'h0700};
    logic [12:0] sc[5] = '{13'h0002, 13'h0000, 13'h0003, 13'h0001, 13'h001e};
    logic [15:0] sx[5] = '{16'h0600, 16'h063f, 16'h0011, 16'h000f, 16'h0701};
    // dot cases: control, column, expected rgb
    // full colour, fixed and inverted cursor, four colour, then blink styles still in their dark first 32 frames
    logic [12:0] dc[7] = '{13'h0002, 13'h1082, 13'h1082, 13'h0182, 13'h0042, 13'h1282, 13'h0382};
    logic [6:0] dx[7] = '{7'd25, 7'd25, 7'd40, 7'd25, 7'd25, 7'd25, 7'd25};
    logic [2:0] de[7] = '{3'b101, 3'b001, 3'b101, 3'b010, 3'b000, 3'b101, 3'b101};
    initial begin
        n_errors = 0;
        cmp_count = 0;
        presetn = 1'b0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        rd(OFS_CTRL);
        chk("ctrl reset", {19'h0, CTRL_RESET}, rv);
        rd(8'h2c);
        chk("unmapped error", 32'h1, {31'h0, rv_err});
        $display("test registers done");
        wr(OFS_COMPARE, 32'h12);
        for (int k = 0; k < 8; k++) begin
            wr(OFS_PROTECT, 32'h0);
            put(16'h0203, CTRL_RESET, 16'h1234);
            wr(OFS_PROTECT, 32'h0f00);
            put(16'h0203, 13'h0022 | {8'h0, k[2:0], 1'b0, k[0]}, 16'h12a5);
            get(16'h0203, merge(k[2:0], 16'h1234, 16'h12a5, 8'h12, 16'h0f00));
        end
        $display("test merge done");
        wr(OFS_PROTECT, 32'h0);
        for (int i = 0; i < 5; i++) begin
            put(sp[i], sc[i], (i == 4) ? 16'h1212 : 16'h00a0);
            wr(OFS_DATA, 32'h00b0 + i);
            get(sx[i], 16'h00b0 + i[15:0]);
        end
        $display("test stepping done");
        wr(OFS_CTRL, {19'h0, CTRL_RESET});
        // only line 10 is looked at; a four-colour word sits at column 3
        wr(OFS_POINTER, 32'h0a00);
        repeat (64) wr(OFS_DATA, 32'h0);
        wr(OFS_POINTER, 32'h0a03);
        wr(OFS_DATA, 32'h1000);
        wr(OFS_RED_PAL, 32'hf);
        wr(OFS_GREEN_PAL, 32'h0);
        wr(OFS_BLUE_PAL, 32'hf);
        wr(OFS_CUR_H, 32'h1e14);
        wr(OFS_CUR_V, 32'h0f05);
        for (int i = 0; i < 7; i++) begin
            wr(OFS_CTRL, {19'h0, dc[i]});
            dot(dx[i], 7'd10, de[i]);
        end
        $display("test cursor done");
        conclude();
    end
    // cut a hang short
    initial begin
        repeat (90000) @(posedge pclk);
        n_errors++;
        $display("mismatch watchdog expected finish seen timeout");
        conclude();
    end
endmodule : grpc_top_tb
